/* File: core/scan_pkg.sv */
// Constants and carrier types for the front-end scan sequencer.
// Assumes a 20 MHz core clock; all delays become whole cycles of it.
package scan_pkg;

    // ****************************************************************
    // Clock and documented timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS   = 50;
    localparam int T1_HIGH_NS      = 30;   // Strobe high time.
    localparam int T2_SETUP_NS     = 30;   // Strobe fall to first shift edge.
    localparam int T3_DELAY_NS     = 400;  // Last shift edge to reset sample.
    localparam int T4_DELAY_NS     = 30;   // Reset sample to window rise.
    localparam int T5_WINDOW_US    = 14;   // Integration window high time.
    localparam int T6_DELAY_TENTHS = 45;   // Window fall to signal sample, 4.5 us in tenths.
    localparam int T7_DELAY_NS     = 30;   // Signal sample to integrator reset.
    localparam int T8_DELAY_NS     = 30;   // Signal sample to scan start.
    localparam int T9_HOLD_NS      = 10;   // Scan start fall to integrator reset fall.
    localparam int SHIFT_EDGES     = 133;  // Shift edges per scan.

    // Least times round up, and never fall below one cycle.
    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    localparam int CYC_T1 = min_cycles(T1_HIGH_NS);
    localparam int CYC_T2 = min_cycles(T2_SETUP_NS);
    localparam int CYC_T3 = min_cycles(T3_DELAY_NS);
    localparam int CYC_T4 = min_cycles(T4_DELAY_NS);
    localparam int CYC_T5 = min_cycles(T5_WINDOW_US * 1000);
    localparam int CYC_T6 = min_cycles(T6_DELAY_TENTHS * 100);
    localparam int CYC_T7 = min_cycles(T7_DELAY_NS);
    localparam int CYC_T8 = min_cycles(T8_DELAY_NS);
    localparam int CYC_T9 = min_cycles(T9_HOLD_NS);

    // ****************************************************************
    // Defaults and widths
    // ****************************************************************
    localparam int CNT_W          = 10;
    localparam int EDGE_W         = 8;
    localparam int SAMPLE_W       = 16;
    localparam int HALF_PERIOD    = 3;   // 3.33 MHz shift clock at 20 MHz.
    localparam int CAPTURE_EDGES  = 32;
    localparam int FIFO_DEPTH     = 16;
    localparam logic [EDGE_W-1:0] EDGE_RESET = 8'h00;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic scan_start;
        logic integrator_reset;
        logic reset_sample;
        logic signal_sample;
        logic integration_window;
        logic shift_clk;
    } strobes_t;

    typedef struct packed {
        logic [EDGE_W-1:0]   edge_index;
        logic [SAMPLE_W-1:0] level;
    } sample_t;

    localparam strobes_t STROBES_IDLE = 6'h00;

endpackage : scan_pkg

/* File: core/scan_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module scan_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fill side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              empty;
    wire              full;
    wire              push;
    wire              pop;

    // Pointers carry one extra bit so full and empty differ.
    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign push        = in_valid_i && !full;
    assign pop         = out_ready_i && !empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    // Pointer update.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end

    // Storage has no reset; empty flags keep stale words unseen.
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end

endmodule : scan_fifo

`default_nettype wire

/* File: core/scan_sequencer.sv */
// Scan sequencer that drives the front end's strobes and shift clock.
// Assumes an external converter presents the output level on sample_i during each shift-clock low phase.
`timescale 1ns/10ps
`default_nettype none

module scan_sequencer #(
    parameter int HALF_PERIOD   = scan_pkg::HALF_PERIOD,
    parameter int CAPTURE_EDGES = scan_pkg::CAPTURE_EDGES,
    parameter int WINDOW_EXTRA  = 0,
    parameter int FIFO_DEPTH    = scan_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic                          core_clk_i,
    input  wire logic                          rstn_i,
    // Control.
    input  wire logic                          run_i,
    output logic                               busy_o,
    // Front-end pins.
    output scan_pkg::strobes_t                 strobes_o,
    input  wire logic [scan_pkg::SAMPLE_W-1:0] sample_i,
    // Sample stream.
    output logic                               out_valid_o,
    input  wire logic                          out_ready_i,
    output scan_pkg::sample_t                  out_data_o
);

    // ****************************************************************
    // Reset and input synchronisers
    // ****************************************************************
    logic [1:0]                   rst_sync;
    wire                          rst;
    logic [scan_pkg::SAMPLE_W-1:0] sample_meta;
    logic [scan_pkg::SAMPLE_W-1:0] sample_sync;

    // Release reset through two flops; assertion stays asynchronous.
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst = !rst_sync[1];

    // Bus is stable through the low phase, so a plain two-flop pass is safe here.
    always_ff @(posedge core_clk_i)
    begin
        sample_meta <= sample_i;
        sample_sync <= sample_meta;
    end

    // ****************************************************************
    // Sequence state machine
    // ****************************************************************
    typedef enum logic [11:0] {
        S_IDLE          = 12'h001,
        S_RESET_SAMPLE  = 12'h002,
        S_T4            = 12'h004,
        S_WINDOW        = 12'h008,
        S_T6            = 12'h010,
        S_SIGNAL_SAMPLE = 12'h020,
        S_SCAN_START    = 12'h040,
        S_HOLD          = 12'h080,
        S_SETUP         = 12'h100,
        S_CLK_HI        = 12'h200,
        S_CLK_LO        = 12'h400,
        S_T3            = 12'h800
    } state_t;

    localparam logic [scan_pkg::CNT_W-1:0] N_T1    = scan_pkg::CNT_W'(scan_pkg::CYC_T1 - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T4    = scan_pkg::CNT_W'(
        scan_pkg::max2(scan_pkg::CYC_T4 - scan_pkg::CYC_T1, 1) - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T5    = scan_pkg::CNT_W'(scan_pkg::CYC_T5 + WINDOW_EXTRA - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T6    = scan_pkg::CNT_W'(scan_pkg::CYC_T6 - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T78   = scan_pkg::CNT_W'(
        scan_pkg::max2(scan_pkg::max2(scan_pkg::CYC_T7, scan_pkg::CYC_T8), scan_pkg::CYC_T1) - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T9    = scan_pkg::CNT_W'(scan_pkg::CYC_T9 - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T2    = scan_pkg::CNT_W'(scan_pkg::CYC_T2 - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_HALF  = scan_pkg::CNT_W'(HALF_PERIOD - 1);
    localparam logic [scan_pkg::CNT_W-1:0] N_T3    = scan_pkg::CNT_W'(scan_pkg::CYC_T3 - HALF_PERIOD - 1);
    localparam logic [scan_pkg::EDGE_W-1:0] LAST_EDGE = scan_pkg::EDGE_W'(scan_pkg::SHIFT_EDGES);
    localparam logic [scan_pkg::EDGE_W-1:0] CAP_EDGE  = scan_pkg::EDGE_W'(CAPTURE_EDGES);

    state_t                       state;
    state_t                       next_state;
    logic [scan_pkg::CNT_W-1:0]   cnt;
    logic [scan_pkg::CNT_W-1:0]   next_cnt;
    logic [scan_pkg::EDGE_W-1:0]  edge_cnt;
    scan_pkg::strobes_t           next_strobes;
    wire                          expired;
    wire                          capture;
    wire                          fifo_ready;
    wire                          push;
    scan_pkg::sample_t            word;

    assign expired = (cnt == '0);
    // Edge k's channel level is read at the end of the low phase after edge k.
    assign capture = (edge_cnt != scan_pkg::EDGE_RESET) && (edge_cnt <= CAP_EDGE);
    assign push    = (state == S_CLK_LO) && expired && capture && fifo_ready;
    assign word    = '{edge_index: edge_cnt, level: sample_sync};
    assign busy_o  = (state != S_IDLE);

    // Next state and delay load; each wait loads a cycle count rounded up.
    always_comb
    begin
        next_state = state;
        next_cnt   = expired ? cnt : cnt - 1'b1;
        case (state)
            S_IDLE:
                if (run_i)
                begin
                    next_state = S_RESET_SAMPLE;
                    next_cnt   = N_T1;
                end
            S_RESET_SAMPLE:
                if (expired)
                begin
                    next_state = S_T4;
                    next_cnt   = N_T4;
                end
            S_T4:
                if (expired)
                begin
                    next_state = S_WINDOW;
                    next_cnt   = N_T5;
                end
            S_WINDOW:
                if (expired)
                begin
                    next_state = S_T6;
                    next_cnt   = N_T6;
                end
            S_T6:
                if (expired)
                begin
                    next_state = S_SIGNAL_SAMPLE;
                    next_cnt   = N_T78;
                end
            S_SIGNAL_SAMPLE:
                if (expired)
                begin
                    next_state = S_SCAN_START;
                    next_cnt   = N_T1;
                end
            S_SCAN_START:
                if (expired)
                begin
                    next_state = S_HOLD;
                    next_cnt   = N_T9;
                end
            S_HOLD:
                if (expired)
                begin
                    next_state = S_SETUP;
                    next_cnt   = N_T2;
                end
            S_SETUP:
                if (expired)
                begin
                    next_state = S_CLK_HI;
                    next_cnt   = N_HALF;
                end
            S_CLK_HI:
                if (expired)
                begin
                    next_state = (edge_cnt == LAST_EDGE) ? S_T3 : S_CLK_LO;
                    next_cnt   = (edge_cnt == LAST_EDGE) ? N_T3 : N_HALF;
                end
            // A full FIFO stretches the low phase; the drain side must keep the clock above its floor.
            S_CLK_LO:
                if (expired && (!capture || fifo_ready))
                begin
                    next_state = S_CLK_HI;
                    next_cnt   = N_HALF;
                end
            S_T3:
                if (expired)
                begin
                    next_state = run_i ? S_RESET_SAMPLE : S_IDLE;
                    next_cnt   = N_T1;
                end
            default:  begin next_state = S_IDLE; next_cnt = '0; end
        endcase
    end

    // Pin levels follow the state; registered so the pins never glitch.
    always_comb
    begin
        next_strobes                    = scan_pkg::STROBES_IDLE;
        next_strobes.reset_sample       = (next_state == S_RESET_SAMPLE);
        next_strobes.integration_window = (next_state == S_WINDOW);
        next_strobes.signal_sample      = (next_state == S_SIGNAL_SAMPLE);
        next_strobes.scan_start         = (next_state == S_SCAN_START);
        next_strobes.integrator_reset   = (next_state == S_SCAN_START) || (next_state == S_HOLD);
        next_strobes.shift_clk          = (next_state == S_CLK_HI);
    end

    // State, delay counter and pins.
    always_ff @(posedge core_clk_i or posedge rst)
    begin
        if (rst)
        begin
            state     <= S_IDLE;
            cnt       <= '0;
            strobes_o <= scan_pkg::STROBES_IDLE;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            strobes_o <= next_strobes;
        end
    end

    // Rising edges within the scan; cleared when the scan start pulse goes out.
    always_ff @(posedge core_clk_i or posedge rst)
    begin
        if (rst)
            edge_cnt <= scan_pkg::EDGE_RESET;
        else if (next_state == S_SCAN_START)
            edge_cnt <= scan_pkg::EDGE_RESET;
        else if ((next_state == S_CLK_HI) && (state != S_CLK_HI))
            edge_cnt <= edge_cnt + 1'b1;
    end

    // ****************************************************************
    // Sample buffer
    // ****************************************************************
    scan_fifo #(
        .WIDTH ($bits(scan_pkg::sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (core_clk_i),
        .rst_i       (rst),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (word),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_data_o)
    );

endmodule : scan_sequencer

`default_nettype wire

/* File: testbench/scan_sequencer_props.sv */
// Checker on the sequencer's strobe pins.
// Assumes the package's cycle figures and one clock domain.
`timescale 1ns/10ps
`default_nettype none
module scan_sequencer_props #(parameter int WINDOW_EXTRA = 0) (
    // Clock, reset and strobes.
    input wire logic               core_clk_i,
    input wire logic               rstn_i,
    input wire scan_pkg::strobes_t strobes_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    scan_pkg::strobes_t s;
    logic               iw_q, sh_q;
    int                 len, since;
    assign s = strobes_o;
    // Cycles since the window changed and since the last shift rise; since starts satisfied.
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            {iw_q, sh_q, len, since} <= {2'b00, 32'd0, 32'(scan_pkg::CYC_T3)};
        else
        begin
            {iw_q, sh_q} <= {s.integration_window, s.shift_clk};
            len          <= (s.integration_window != iw_q) ? 1 : len + 1;
            since        <= (s.shift_clk && !sh_q) ? 1 : since + 1;
        end
    end
    property p_reset_width; $rose(s.integrator_reset) |-> s.integrator_reset[*2] ##1 !s.integrator_reset; endproperty
    a_reset_width: assert property (p_reset_width) else $error("integrator reset width wrong");
    // Scan start low, then integrator reset low, then one setup cycle before the first shift rise.
    property p_shift_setup; $fell(s.scan_start) |-> (!s.shift_clk)[*2]; endproperty
    a_shift_setup: assert property (p_shift_setup) else $error("shift edge too early");
    property p_sample_delay; $rose(s.reset_sample) |-> since >= scan_pkg::CYC_T3; endproperty
    a_sample_delay: assert property (p_sample_delay) else $error("reset sample too early");
    property p_window_after; $rose(s.reset_sample) |-> (!s.integration_window)[*2] ##1 s.integration_window; endproperty
    a_window_after: assert property (p_window_after) else $error("window start wrong");
    property p_window_len; $fell(s.integration_window) |-> len >= scan_pkg::CYC_T5 + WINDOW_EXTRA; endproperty
    a_window_len: assert property (p_window_len) else $error("window too short");
    property p_gap; $rose(s.signal_sample) |-> !s.integration_window && len >= scan_pkg::CYC_T6; endproperty
    a_gap: assert property (p_gap) else $error("signal sample too early");
    property p_resets_after; $rose(s.signal_sample) |=> $rose(s.scan_start) && $rose(s.integrator_reset); endproperty
    a_resets_after: assert property (p_resets_after) else $error("resets not after signal sample");
    property p_reset_hold; $fell(s.scan_start) |-> s.integrator_reset ##1 !s.integrator_reset; endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("integrator reset hold wrong");
    c_window: cover property ($fell(s.integration_window));
    c_signal: cover property ($rose(s.signal_sample));
    c_repeat: cover property ($rose(s.reset_sample) && since < 20);
endmodule : scan_sequencer_props
bind scan_sequencer scan_sequencer_props #(.WINDOW_EXTRA(WINDOW_EXTRA)) props_u (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .strobes_o(strobes_o));
`default_nettype wire

/* File: testbench/front_end_model.sv */
// Front-end model: channel counter and channel level.
// Assumes strobes change just after core clock edges.
`timescale 1ns/10ps
`default_nettype none
module front_end_model (
    // Clock, reset, strobes in, level out.
    input  wire logic                          clk_i,
    input  wire logic                          rstn_i,
    input  wire scan_pkg::strobes_t            strobes_i,
    output logic [scan_pkg::SAMPLE_W-1:0]      sample_o
);
    scan_pkg::strobes_t p;
    logic [7:0]         chan;
    logic               out_en, toggle, discharged, baseline;
    // Until the first scan start falls, and while each scan start pulse is high, the driver is idle, so the level flips each cycle.
    assign sample_o = out_en ? 16'h0a00 + {8'h00, chan} : {16{toggle}};
    // Reaction to the strobe edges.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            {p, chan, out_en, toggle, discharged, baseline} <= '0;
        else
        begin
            p      <= strobes_i;
            toggle <= ~toggle;
            if (strobes_i.scan_start && !p.scan_start)
                chan <= 8'h00;
            if (strobes_i.scan_start != p.scan_start)
                out_en <= p.scan_start;
            if (strobes_i.shift_clk && !p.shift_clk && out_en)
                chan <= chan + 8'h01;
            if (strobes_i.integrator_reset)
                discharged <= 1'b1;
            if (strobes_i.reset_sample && !p.reset_sample)
                baseline <= discharged;
        end
    end
endmodule : front_end_model
`default_nettype wire

/* File: testbench/scan_sequencer_test.sv */
// Bench for the scan sequencer with a front-end model.
// Assumes package, FIFO, sequencer, model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module scan_sequencer_test;
    logic               core_clk = 1'b0, rstn = 1'b0, run = 1'b0, rdy = 1'b0;
    logic               busy, vld;
    logic [15:0]        level;
    scan_pkg::strobes_t stb, prev;
    scan_pkg::sample_t  word;
    int                 failures = 0, num_checks = 0, edges = 0, rises = 0;
    always #25 core_clk = ~core_clk;
    scan_sequencer dut_u (.core_clk_i(core_clk), .rstn_i(rstn), .run_i(run), .busy_o(busy), .strobes_o(stb),
        .sample_i(level), .out_valid_o(vld), .out_ready_i(rdy), .out_data_o(word));
    front_end_model model_u (.clk_i(core_clk), .rstn_i(rstn), .strobes_i(stb), .sample_o(level));
    // Count shift and reset-sample rises as the front end sees them.
    always @(posedge core_clk)
    begin
        edges += int'(stb.shift_clk && !prev.shift_clk);
        rises += int'(stb.reset_sample && !prev.reset_sample);
        prev = stb;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        failures += int'(seen !== exp);
        if (seen !== exp)
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    endtask : check
    task automatic print_verdict();
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic give_up();
        check(32'h0, 32'h1);
        print_verdict();
    endtask : give_up
    task automatic wait_idle();
        for (int i = 0; i < 5000 && busy !== 1'b0; i++)
            @(posedge core_clk);
        if (busy !== 1'b0)
            give_up();
    endtask : wait_idle
    // Words arrive in edge order; the level is 0x0a00 plus the model's channel count.
    task automatic drain(input int n);
        int k = 0;
        for (int t = 0; t < 5000 && k < n; t++)
        begin
            @(posedge core_clk);
            if (vld === 1'b1 && rdy === 1'b1)
            begin
                k++;
                check(word, {8'(k), 16'h0a00 + 16'(k)});
            end
        end
        if (k < n)
            give_up();
    endtask : drain
    // A one-edge run request; the full FIFO must stall the shift clock.
    task automatic stalled_scan();
        run <= 1'b1;
        @(posedge core_clk);
        run <= 1'b0;
        repeat (900) @(posedge core_clk);
        check(edges, 17);
        check(vld, 1'b1);
        rdy <= 1'b1;
        drain(32);
        wait_idle();
        check(edges, 133);
        check(rises, 1);
    endtask : stalled_scan
    // Two scans back to back; run stays high until the second scan is shifting, so it is seen at the first scan's end.
    task automatic back_to_back();
        run <= 1'b1;
        drain(32);
        drain(32);
        run <= 1'b0;
        wait_idle();
        check(edges, 399);
        check(rises, 3);
    endtask : back_to_back
    // Reset in mid-window must drop every strobe at once.
    task automatic reset_mid_scan();
        run <= 1'b1;
        repeat (100) @(posedge core_clk);
        rstn <= 1'b0;
        run <= 1'b0;
        @(negedge core_clk);
        check(stb, scan_pkg::STROBES_IDLE);
        check(busy, 1'b0);
        check(vld, 1'b0);
        // Reset is held for several edges so no checker attempt sees the drop with reset already gone.
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(busy, 1'b0);
        check(stb, scan_pkg::STROBES_IDLE);
        @(posedge core_clk);
        run <= 1'b1;
        @(posedge core_clk);
        run <= 1'b0;
        drain(32);
        wait_idle();
        check(edges, 532);
        check(rises, 5);
    endtask : reset_mid_scan
    initial
    begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        stalled_scan();
        back_to_back();
        reset_mid_scan();
        print_verdict();
    end
endmodule : scan_sequencer_test
`default_nettype wire
